// File: lgds_pkg.sv
// Purpose: Shared constants for the legacy display status register bank.
// Assumes: Byte-addressed I/O or memory offsets, 16-bit address, 16-bit data.
// Notes:   Memory offsets equal I/O offsets, so one map serves both spaces.
package lgds_pkg;

  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned LANES  = 2;
  localparam int unsigned NPIPE  = 2;
  localparam int unsigned SYNC_W = 11;

  // Register offsets
  localparam logic [15:0] ADDR_STATUS_ZERO     = 16'h03c2;
  localparam logic [15:0] ADDR_MISC_WR         = 16'h03c2;
  localparam logic [15:0] ADDR_STATUS_ONE_MONO = 16'h03ba;
  localparam logic [15:0] ADDR_STATUS_ONE_CLR  = 16'h03da;
  localparam logic [15:0] ADDR_FEATURE_RD      = 16'h03ca;
  localparam logic [15:0] ADDR_MISC_RD         = 16'h03cc;

  // Field positions
  localparam int unsigned ST1_DISP_BIT  = 0;
  localparam int unsigned ST1_VRTR_BIT  = 3;
  localparam int unsigned ST1_FB_LO     = 4;
  localparam int unsigned MISC_EMU_BIT  = 0;
  localparam int unsigned FEAT_VSC_BIT  = 3;

  // Constant and mask values
  localparam logic [7:0] STATUS_ZERO_VALUE = 8'h10;
  localparam logic [7:0] MISC_RW_MASK      = 8'hef;
  localparam logic [7:0] FEATURE_RW_MASK   = 8'h08;

  // Reset values
  localparam logic [7:0] MISC_RESET        = 8'h00;
  localparam logic [7:0] FEATURE_RESET     = 8'h00;

endpackage

// File: lgds_status_if.sv
// Purpose: Carries synchronised pipe status from the synchroniser to the core.
// Assumes: One clock domain on the register side.
// Notes:   Colour bits feed the video feedback selector.
`timescale 1ns/1ps
interface lgds_status_if;
  logic       vretrace;
  logic       blank;
  logic [7:0] color;
  modport src (output vretrace, output blank, output color);
  modport dst (input vretrace, input blank, input color);
endinterface

// File: lgds_sync.sv
// Purpose: Two-stage synchroniser for the legacy pipe status levels.
// Assumes: Inputs are levels from the pipe timing, possibly another clock.
// Notes:   The first stage is read by the second stage only.
`timescale 1ns/1ps
module lgds_sync
  import lgds_pkg::*;
(
  // Clock and reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_reset,
  // Raw status
  input  wire logic [SYNC_W-1:0] i_raw,
  // Synchronised status
  lgds_status_if.src             o_stat
);

  logic [SYNC_W-1:0] meta_q, meta_d;
  logic [SYNC_W-1:0] sync_q, sync_d;

  always_comb begin
    meta_d = i_raw;
    sync_d = meta_q;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign o_stat.color    = sync_q[7:0];
  assign o_stat.blank    = sync_q[8];
  assign o_stat.vretrace = sync_q[9];

endmodule

// File: lgds_feedback.sv
// Purpose: Picks two of the eight palette colour bits for status feedback.
// Assumes: Select comes from the colour plane enable field held elsewhere.
// Notes:   Pure combinational; the top registers the read result.
`timescale 1ns/1ps
module lgds_feedback
  import lgds_pkg::*;
(
  // Synchronised status
  lgds_status_if.dst       i_stat,
  // Colour plane enable bits 5:4
  input  wire logic [1:0]  i_sel,
  // Selected pair
  output logic      [1:0]  o_pair
);

  // Pairs interleave so each select covers a distinct plane pair
  always_comb begin
    unique case (i_sel)
      2'b00: o_pair = {i_stat.color[2], i_stat.color[0]};
      2'b01: o_pair = {i_stat.color[5], i_stat.color[4]};
      2'b10: o_pair = {i_stat.color[3], i_stat.color[1]};
      2'b11: o_pair = {i_stat.color[7], i_stat.color[6]};
    endcase
  end

endmodule

// File: lgds_top.sv
// Purpose: Legacy display general control and status registers.
// Assumes: Byte or naturally aligned word accesses; one-cycle request strobes.
// Notes:   Status levels pass a two-flop synchroniser before they are read.
`timescale 1ns/1ps
module lgds_top
  import lgds_pkg::*;
(
  // Clock and reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_reset,
  // Host access port
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [LANES-1:0]  i_byte_en,
  input  wire logic              i_rd,
  input  wire logic              i_wr,
  input  wire logic [DATA_W-1:0] i_wdata,
  output logic      [DATA_W-1:0] o_rdata,
  output logic                   o_ack,
  output logic                   o_claim,
  // Pipe status; retrace and blank per pipe, one colour bus, legacy pipe select
  input  wire logic [NPIPE-1:0]  i_pipe_vretrace,
  input  wire logic [NPIPE-1:0]  i_pipe_hblank,
  input  wire logic [NPIPE-1:0]  i_pipe_vblank,
  input  wire logic [7:0]        i_pipe_color,
  input  wire logic              i_legacy_pipe_sel,
  // Colour plane enable bits 5:4
  input  wire logic [1:0]        i_color_plane_sel,
  // Control outputs
  output logic                   o_emu_color,
  output logic [7:0]             o_misc_output
);

  lgds_status_if stat ();

  logic [SYNC_W-1:0] raw_status;
  logic [1:0]        fb_pair;

  logic [7:0]        misc_q, misc_d;
  logic [7:0]        feat_q, feat_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic              ack_q, ack_d;
  logic              claim_q, claim_d;
  logic [7:0]        status_one;

  // Any legal request uses at least one lane
  function automatic logic [ADDR_W-1:0] lane_addr(input logic [ADDR_W-1:0] a,
                                                   input int unsigned lane);
    lane_addr = {a[ADDR_W-1:1], lane[0]};
  endfunction

  // Both groups always answer, whatever the emulation select
  function automatic logic is_status_one(input logic [ADDR_W-1:0] a);
    is_status_one = (a == ADDR_STATUS_ONE_MONO) || (a == ADDR_STATUS_ONE_CLR);
  endfunction

  function automatic logic rd_hit(input logic [ADDR_W-1:0] a);
    rd_hit = (a == ADDR_STATUS_ZERO) || is_status_one(a) ||
             (a == ADDR_FEATURE_RD) || (a == ADDR_MISC_RD);
  endfunction

  function automatic logic wr_hit(input logic [ADDR_W-1:0] a);
    wr_hit = (a == ADDR_MISC_WR) || is_status_one(a);
  endfunction

  // Pick the assigned pipe even with legacy display off
  always_comb begin
    raw_status[7:0] = i_pipe_color;
    // Blank covers porches plus sync, wider than the sync pulse
    raw_status[8]   = i_pipe_hblank[i_legacy_pipe_sel] |
                      i_pipe_vblank[i_legacy_pipe_sel];
    // Pixel generator retrace, not the panel's sync pulse
    raw_status[9]   = i_pipe_vretrace[i_legacy_pipe_sel];
    raw_status[10]  = 1'b0;
  end

  lgds_sync u_sync (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_raw     (raw_status),
    .o_stat    (stat)
  );

  lgds_feedback u_feedback (
    .i_stat (stat),
    .i_sel  (i_color_plane_sel),
    .o_pair (fb_pair)
  );

  always_comb begin
    status_one                = 8'h00;
    status_one[ST1_DISP_BIT]  = stat.blank;
    status_one[ST1_VRTR_BIT]  = stat.vretrace;
    status_one[ST1_FB_LO+:2]  = fb_pair;
  end

  // Reads have no side effects; no interrupt path exists here
  always_comb begin
    logic [ADDR_W-1:0] a;
    a         = '0;
    misc_d    = misc_q;
    feat_d    = feat_q;
    rdata_d   = rdata_q;
    ack_d     = i_rd | i_wr;
    claim_d   = 1'b0;
    for (int unsigned l = 0; l < LANES; l++) begin
      a = lane_addr(i_addr, l);
      if (i_byte_en[l] && i_wr && wr_hit(a)) begin
        claim_d = 1'b1;
        if (a == ADDR_MISC_WR) begin
          misc_d = i_wdata[8*l+:8] & MISC_RW_MASK;
        end else begin
          // Status one is read-only, so this offset writes feature control
          feat_d = i_wdata[8*l+:8] & FEATURE_RW_MASK;
        end
      end
      if (i_rd) begin
        rdata_d[8*l+:8] = 8'h00;
      end
      if (i_byte_en[l] && i_rd && rd_hit(a)) begin
        claim_d = 1'b1;
        if (a == ADDR_STATUS_ZERO) begin
          rdata_d[8*l+:8] = STATUS_ZERO_VALUE;
        end else if (is_status_one(a)) begin
          rdata_d[8*l+:8] = status_one;
        end else if (a == ADDR_FEATURE_RD) begin
          rdata_d[8*l+:8] = feat_q;
        end else begin
          rdata_d[8*l+:8] = misc_q;
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      misc_q  <= MISC_RESET;
      feat_q  <= FEATURE_RESET;
      rdata_q <= '0;
      ack_q   <= 1'b0;
      claim_q <= 1'b0;
    end else begin
      misc_q  <= misc_d;
      feat_q  <= feat_d;
      rdata_q <= rdata_d;
      ack_q   <= ack_d;
      claim_q <= claim_d;
    end
  end

  assign o_rdata       = rdata_q;
  assign o_ack         = ack_q;
  assign o_claim       = claim_q;
  assign o_misc_output = misc_q;
  assign o_emu_color   = misc_q[MISC_EMU_BIT];

endmodule

// File: lgds_chk_asserts.sv
// Purpose: Port-level assertions for the legacy display status registers.
// Assumes: One clock domain; requests are one-cycle strobes.
// Notes:   Sees only top-level ports; attached by bind from the bench.
`timescale 1ns/1ps
module lgds_chk
  import lgds_pkg::*;
(
  // Clock and reset
  input wire logic              i_ref_clk,
  input wire logic              i_reset,
  // Host port
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [LANES-1:0]  i_byte_en,
  input wire logic              i_rd,
  input wire logic              i_wr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic [DATA_W-1:0] o_rdata,
  input wire logic              o_ack,
  input wire logic              o_claim,
  input wire logic              o_emu_color,
  input wire logic [7:0]        o_misc_output
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  wire rd0 = i_rd && i_byte_en[0];
  wire st1 = (i_addr == ADDR_STATUS_ONE_MONO) || (i_addr == ADDR_STATUS_ONE_CLR);
  wire mwr = i_wr && i_byte_en[0] && (i_addr == ADDR_MISC_WR);
  a_ack_follows: assert property ((i_rd || i_wr) |=> o_ack)
    else $error("no ack after request");
  a_ack_only_req: assert property (!(i_rd || i_wr) |=> !o_ack && !o_claim)
    else $error("ack without request");
  a_stat0_value: assert property (rd0 && i_addr == ADDR_STATUS_ZERO |=> o_claim && o_rdata[7:0] == STATUS_ZERO_VALUE)
    else $error("status zero value wrong");
  a_stat1_zeros: assert property (rd0 && st1 |=> o_claim && o_rdata[7:6] == 2'h0 && o_rdata[2:1] == 2'h0)
    else $error("status one reserved bits set");
  a_feat_zeros: assert property (rd0 && i_addr == ADDR_FEATURE_RD |=> (o_rdata[7:0] & ~FEATURE_RW_MASK) == 8'h00)
    else $error("feature reserved bits set");
  a_misc_update: assert property (mwr |=> o_misc_output == ($past(i_wdata[7:0]) & MISC_RW_MASK))
    else $error("misc write not stored");
  a_misc_hold: assert property (!mwr |=> $stable(o_misc_output))
    else $error("misc changed without write");
  a_emu_bit: assert property (o_emu_color == o_misc_output[MISC_EMU_BIT])
    else $error("emulation select mismatch");
  a_rdata_hold: assert property (!i_rd |=> $stable(o_rdata))
    else $error("read data moved between reads");
  c_st1_color: cover property (rd0 && i_addr == ADDR_STATUS_ONE_CLR);
  c_feat_mono: cover property (i_wr && i_addr == ADDR_STATUS_ONE_MONO);
  c_emu_color: cover property (o_emu_color);
endmodule

// File: tb_top.sv
// Purpose: Self-checking bench for the legacy display status registers.
// Assumes: Stimulus at the falling edge; answers one cycle after a strobe.
// Notes:   Pipe levels settle three edges so the synchroniser has passed them.
`timescale 1ns/1ps
module tb_top;
  import lgds_pkg::*;
  logic        i_ref_clk = 0, i_reset = 1, i_rd = 0, i_wr = 0, i_legacy_pipe_sel = 0;
  logic [15:0] i_addr = '0, i_wdata = '0, o_rdata;
  logic [1:0]  i_byte_en = 2'h1, i_pipe_vretrace = '0, i_pipe_hblank = '0;
  logic [1:0]  i_pipe_vblank = '0, i_color_plane_sel = '0;
  logic [7:0]  i_pipe_color = '0, o_misc_output;
  logic        o_ack, o_claim, o_emu_color;
  int          errors = 0, total_checks = 0, misc, feat, p, e;
  int          hi[4] = '{2, 5, 3, 7}, lo[4] = '{0, 4, 1, 6};
  always #20 i_ref_clk = ~i_ref_clk;
  lgds_top i_dut (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_addr(i_addr),
    .i_byte_en(i_byte_en), .i_rd(i_rd), .i_wr(i_wr), .i_wdata(i_wdata), .o_rdata(o_rdata),
    .o_ack(o_ack), .o_claim(o_claim), .i_pipe_vretrace(i_pipe_vretrace),
    .i_pipe_hblank(i_pipe_hblank), .i_pipe_vblank(i_pipe_vblank), .i_pipe_color(i_pipe_color),
    .i_legacy_pipe_sel(i_legacy_pipe_sel), .i_color_plane_sel(i_color_plane_sel),
    .o_emu_color(o_emu_color), .o_misc_output(o_misc_output));
  task automatic chk(input logic [7:0] got, input int exp);
    total_checks++;
    if (got !== exp[7:0]) begin
      errors++;
      $display("BAD %0t: got %h want %h", $time, got, exp[7:0]);
    end
  endtask
  // One strobe; exp < 0 skips data, cl < 0 skips the claim flag
  // Ack and claim stand one cycle only, so they are looked at before the next edge
  task automatic acc(input logic wr, input logic [15:0] a, input logic [7:0] d,
                     input int exp, input int cl);
    i_addr = a;
    i_wdata = {8'h00, d};
    i_rd = !wr;
    i_wr = wr;
    @(negedge i_ref_clk);
    i_rd = 0;
    i_wr = 0;
    chk({7'h0, o_ack}, 1);
    if (cl >= 0) chk({7'h0, o_claim}, cl);
    if (exp >= 0) chk(o_rdata[7:0], exp);
    // Idle edge so the next strobe is not raised in the step that lowered this one
    @(negedge i_ref_clk);
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(94321));
    repeat (3) @(negedge i_ref_clk);
    i_reset = 0;
    acc(0, ADDR_FEATURE_RD, 0, 0, 1);
    acc(0, ADDR_MISC_RD, 0, 0, 1);
    for (int k = 0; k < 6; k++) begin
      e = $urandom;
      acc(1, ADDR_MISC_WR, e[7:0], -1, 1);
      misc = e & 8'hef;
      chk(o_misc_output, misc);
      chk({7'h0, o_emu_color}, misc & 1);
      acc(0, ADDR_MISC_RD, 0, misc, 1);
      acc(0, ADDR_STATUS_ZERO, 0, 8'h10, 1);
      acc(1, k[0] ? ADDR_STATUS_ONE_CLR : ADDR_STATUS_ONE_MONO, e[15:8], -1, 1);
      feat = e[15:8] & 8'h08;
      acc(1, ADDR_FEATURE_RD, ~e[15:8], -1, -1);
      acc(0, ADDR_FEATURE_RD, 0, feat, 1);
    end
    for (int k = 0; k < 24; k++) begin
      {i_pipe_vretrace, i_pipe_hblank, i_pipe_vblank, i_color_plane_sel} = 8'($urandom);
      i_pipe_color = 8'($urandom);
      i_legacy_pipe_sel = 1'($urandom);
      repeat (3) @(negedge i_ref_clk);
      p = i_legacy_pipe_sel;
      e = {i_pipe_color[hi[i_color_plane_sel]], i_pipe_color[lo[i_color_plane_sel]],
           i_pipe_vretrace[p], 2'b00, i_pipe_hblank[p] | i_pipe_vblank[p]};
      acc(0, k[0] ? ADDR_STATUS_ONE_CLR : ADDR_STATUS_ONE_MONO, 0, e, 1);
    end
    acc(0, 16'h0100, 0, 0, 0);
    acc(1, 16'h0100, 8'hff, -1, 0);
    i_reset = 1;
    repeat (2) @(negedge i_ref_clk);
    i_reset = 0;
    acc(0, ADDR_FEATURE_RD, 0, 0, 1);
    give_verdict;
  end
  // Run takes about 210 cycles; allow ample margin
  initial begin
    #100us;
    errors++;
    give_verdict;
  end
endmodule
bind lgds_top lgds_chk i_chk (.i_ref_clk, .i_reset, .i_addr, .i_byte_en, .i_rd, .i_wr,
  .i_wdata, .o_rdata, .o_ack, .o_claim, .o_emu_color, .o_misc_output);
